// File: hdl/pitf_pkg.sv
// Constants for the port, LED and timer-flag instruction group.
// Assumes a 10-bit instruction word and a 4-bit accumulator in the core.
package pitf_pkg;

  // Instruction codes
  localparam logic [9:0] OP_SKIP_T1       = 10'h280;
  localparam logic [9:0] OP_SKIP_T2       = 10'h281;
  localparam logic [9:0] OP_SKIP_T3       = 10'h282;
  localparam logic [9:0] OP_SKIP_T4       = 10'h283;
  localparam logic [9:0] OP_RD_PORT_ZERO  = 10'h260;
  localparam logic [9:0] OP_WR_PORT_ZERO  = 10'h220;
  localparam logic [9:0] OP_RD_PORT_ONE   = 10'h261;
  localparam logic [9:0] OP_WR_PORT_ONE   = 10'h221;
  localparam logic [9:0] OP_RD_PORT_TWO   = 10'h262;
  localparam logic [9:0] OP_WR_PORT_TWO   = 10'h222;
  localparam logic [9:0] OP_RD_PORT_THREE = 10'h263;
  localparam logic [9:0] OP_WR_PORT_THREE = 10'h223;
  localparam logic [9:0] OP_RD_PORT_SIX   = 10'h266;
  localparam logic [9:0] OP_WR_PORT_SIX   = 10'h226;
  localparam logic [9:0] OP_SET_ALL_LED   = 10'h011;
  localparam logic [9:0] OP_CLR_LED_BIT   = 10'h014;
  localparam logic [9:0] OP_SET_LED_BIT   = 10'h015;
  localparam logic [9:0] OP_SKIP_LED_ZERO = 10'h024;
  localparam logic [9:0] OP_RD_PULLUP_0   = 10'h257;
  localparam logic [9:0] OP_WR_PULLUP_0   = 10'h22d;
  localparam logic [9:0] OP_RD_PULLUP_1   = 10'h25e;
  localparam logic [9:0] OP_WR_PULLUP_1   = 10'h22e;

  // Interrupt enable bit positions inside the two control registers
  localparam int IE_T1_BIT = 2;
  localparam int IE_T2_BIT = 3;
  localparam int IE_T3_BIT = 0;
  localparam int IE_T4_BIT = 1;

  // Positions inside the packed pin vector
  localparam int PIN_W     = 17;
  localparam int P0_LSB    = 0;
  localparam int P1_LSB    = 4;
  localparam int P2_LSB    = 8;
  localparam int P3_LSB    = 11;
  localparam int P6_LSB    = 13;

  // Register word indexes (byte address = 4 * index)
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_MASK   = 3'h1;
  localparam logic [2:0] REG_PINS   = 3'h2;
  localparam logic [2:0] REG_STATE  = 3'h3;

  // Status bit layout: bits 3..0 flag consumed by skip, bit 4 bad index
  localparam int EV_W          = 5;
  localparam int EV_BAD_INDEX  = 4;

  // Reset values
  localparam logic [7:0]      LED_RST    = 8'h00;
  localparam logic [3:0]      PULLUP_RST = 4'h0;
  localparam logic [3:0]      PORT_RST   = 4'h0;
  localparam logic [3:0]      TFLAG_RST  = 4'h0;
  localparam logic [EV_W-1:0] STATUS_RST = 5'h00;
  localparam logic [EV_W-1:0] MASK_RST   = 5'h00;

endpackage : pitf_pkg

// File: hdl/pitf_core.sv
// Execution logic for port I/O, LED port bit and timer-flag skip instructions,
// plus an Avalon-MM slave for status, mask and observation registers.
// Assumes the core presents one instruction per cycle with instr_valid and
// takes acc_out when acc_wr pulses; pins arrive asynchronously.
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module pitf_core
  import pitf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        instr_valid,
  input  wire logic [9:0]  instr_code,
  input  wire logic [3:0]  acc_in,
  input  wire logic [3:0]  index_y,
  input  wire logic [3:0]  int_control_reg_1,
  input  wire logic [3:0]  int_control_reg_2,
  input  wire logic [3:0]  timer_flag_set,
  output logic      [3:0]  timer_flag,
  output logic             instr_done,
  output logic             acc_wr,
  output logic      [3:0]  acc_out,
  output logic             skip,
  input  wire logic [3:0]  port_zero_in,
  input  wire logic [3:0]  port_one_in,
  input  wire logic [2:0]  port_two_in,
  input  wire logic [1:0]  port_three_in,
  input  wire logic [3:0]  port_six_in,
  output logic      [3:0]  port_zero_out,
  output logic      [3:0]  port_one_out,
  output logic      [2:0]  port_two_out,
  output logic      [1:0]  port_three_out,
  output logic      [3:0]  port_six_out,
  output logic      [7:0]  led_port,
  output logic      [3:0]  pullup_ctrl_0,
  output logic      [3:0]  pullup_ctrl_1,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             irq
);

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [PIN_W-1:0] sync3;
    logic [PIN_W-1:0] pin_level;
    logic [3:0]       p0;
    logic [3:0]       p1;
    logic [2:0]       p2;
    logic [1:0]       p3;
    logic [3:0]       p6;
    logic [7:0]       led;
    logic [3:0]       pu0;
    logic [3:0]       pu1;
    logic [3:0]       tflag;
    logic             done;
    logic             acc_wr;
    logic [3:0]       acc;
    logic             skip;
    logic [EV_W-1:0]  status;
    logic [EV_W-1:0]  mask;
    logic             bus_ack;
    logic [31:0]      rdata;
  } pitf_state_s;

  pitf_state_s q;
  pitf_state_s next_q;

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] agree;
  logic [3:0]       ien;
  logic [3:0]       flag_clr;
  logic [EV_W-1:0]  ev;
  logic [EV_W-1:0]  w1c;
  logic [2:0]       yb;
  logic             y_ok;
  logic             bus_req;

  assign pins_raw = {port_six_in, port_three_in, port_two_in, port_one_in, port_zero_in};
  assign ien      = {int_control_reg_2[IE_T4_BIT], int_control_reg_2[IE_T3_BIT],
                     int_control_reg_1[IE_T2_BIT], int_control_reg_1[IE_T1_BIT]};
  assign yb       = index_y[2:0];
  assign y_ok     = (index_y[3] == 1'b0);
  assign bus_req  = read | write;

  always_comb begin
    next_q         = q;
    next_q.done    = 1'b0;
    next_q.acc_wr  = 1'b0;
    next_q.skip    = 1'b0;
    flag_clr       = 4'h0;
    ev             = '0;
    w1c            = '0;
    // Three-stage sampling; a bit moves once stages two and three agree
    next_q.sync1     = pins_raw;
    next_q.sync2     = q.sync1;
    next_q.sync3     = q.sync2;
    agree            = ~(q.sync2 ^ q.sync3);
    next_q.pin_level = (q.sync2 & agree) | (q.pin_level & ~agree);

    if (instr_valid) begin
      next_q.done = 1'b1;
      unique case (instr_code)
        OP_SKIP_T1, OP_SKIP_T2, OP_SKIP_T3, OP_SKIP_T4: begin
          // Enabled interrupt leaves the flag to the interrupt logic
          if (!ien[instr_code[1:0]] && q.tflag[instr_code[1:0]]) begin
            next_q.skip               = 1'b1;
            flag_clr[instr_code[1:0]] = 1'b1;
            ev[instr_code[1:0]]       = 1'b1;
          end
        end
        OP_RD_PORT_ZERO: begin
          next_q.acc_wr = 1'b1;
          next_q.acc    = q.pin_level[P0_LSB +: 4];
        end
        OP_WR_PORT_ZERO: next_q.p0 = acc_in;
        OP_RD_PORT_ONE: begin
          next_q.acc_wr = 1'b1;
          next_q.acc    = q.pin_level[P1_LSB +: 4];
        end
        OP_WR_PORT_ONE: next_q.p1 = acc_in;
        OP_RD_PORT_TWO: begin
          next_q.acc_wr = 1'b1;
          next_q.acc    = {1'b0, q.pin_level[P2_LSB +: 3]};
        end
        OP_WR_PORT_TWO: next_q.p2 = acc_in[2:0];
        OP_RD_PORT_THREE: begin
          next_q.acc_wr = 1'b1;
          next_q.acc    = {q.acc[3:2], q.pin_level[P3_LSB +: 2]};
        end
        OP_WR_PORT_THREE: next_q.p3 = acc_in[1:0];
        OP_RD_PORT_SIX: begin
          next_q.acc_wr = 1'b1;
          next_q.acc    = q.pin_level[P6_LSB +: 4];
        end
        OP_WR_PORT_SIX: next_q.p6 = acc_in;
        OP_SET_ALL_LED: next_q.led = 8'hff;
        OP_CLR_LED_BIT: begin
          if (y_ok) next_q.led[yb] = 1'b0;
          else ev[EV_BAD_INDEX] = 1'b1;
        end
        OP_SET_LED_BIT: begin
          if (y_ok) next_q.led[yb] = 1'b1;
          else ev[EV_BAD_INDEX] = 1'b1;
        end
        OP_SKIP_LED_ZERO: begin
          if (y_ok) next_q.skip = ~q.led[yb];
          else ev[EV_BAD_INDEX] = 1'b1;
        end
        OP_RD_PULLUP_0: begin
          next_q.acc_wr = 1'b1;
          next_q.acc    = q.pu0;
        end
        OP_WR_PULLUP_0: next_q.pu0 = acc_in;
        OP_RD_PULLUP_1: begin
          next_q.acc_wr = 1'b1;
          next_q.acc    = q.pu1;
        end
        OP_WR_PULLUP_1: next_q.pu1 = acc_in;
        default: next_q.done = 1'b1;
      endcase
    end

    // New timer events win over a clear in the same cycle
    next_q.tflag = (q.tflag & ~flag_clr) | timer_flag_set;

    // Bus: first cycle of a request waits, second completes
    next_q.bus_ack = bus_req & ~q.bus_ack;
    if (read && !q.bus_ack) begin
      unique case (address[4:2])
        REG_STATUS: next_q.rdata = {27'h0, q.status};
        REG_MASK:   next_q.rdata = {27'h0, q.mask};
        REG_PINS:   next_q.rdata = {15'h0, q.pin_level};
        REG_STATE:  next_q.rdata = {12'h0, q.tflag, q.pu1, q.pu0, q.led};
        default:    next_q.rdata = 32'h0;
      endcase
    end
    if (write && q.bus_ack && byteenable[0]) begin
      if (address[4:2] == REG_STATUS) w1c = writedata[EV_W-1:0];
      if (address[4:2] == REG_MASK) next_q.mask = writedata[EV_W-1:0];
    end
    // Sticky status; a new event wins over a write-one clear
    next_q.status = (q.status & ~w1c) | ev;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q           <= '0;
      q.p0        <= PORT_RST;
      q.p1        <= PORT_RST;
      q.p2        <= PORT_RST[2:0];
      q.p3        <= PORT_RST[1:0];
      q.p6        <= PORT_RST;
      q.led       <= LED_RST;
      q.pu0       <= PULLUP_RST;
      q.pu1       <= PULLUP_RST;
      q.tflag     <= TFLAG_RST;
      q.status    <= STATUS_RST;
      q.mask      <= MASK_RST;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign timer_flag     = q.tflag;
  assign instr_done     = q.done;
  assign acc_wr         = q.acc_wr;
  assign acc_out        = q.acc;
  assign skip           = q.skip;
  assign port_zero_out  = q.p0;
  assign port_one_out   = q.p1;
  assign port_two_out   = q.p2;
  assign port_three_out = q.p3;
  assign port_six_out   = q.p6;
  assign led_port       = q.led;
  assign pullup_ctrl_0  = q.pu0;
  assign pullup_ctrl_1  = q.pu1;
  assign readdata       = q.rdata;
  assign waitrequest    = bus_req & ~q.bus_ack;
  assign irq            = |(q.status & q.mask);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic fire;
  assign fire = ce && instr_valid;

  genvar t;
  for (t = 0; t < 4; t++) begin : g_tf
    tflag_skip_a: assert property (
      fire && instr_code == (OP_SKIP_T1 | 10'(t)) && !ien[t] && q.tflag[t] && !timer_flag_set[t]
      |=> skip && !timer_flag[t])
      else $error("flag test did not skip and clear");
    tflag_nop_a: assert property (
      fire && instr_code == (OP_SKIP_T1 | 10'(t)) && ien[t]
      |=> !skip && timer_flag[t] == ($past(q.tflag[t]) | $past(timer_flag_set[t])))
      else $error("enabled flag test was not a no-op");
  end

  port_zero_rd_a: assert property (
    fire && instr_code == OP_RD_PORT_ZERO |=> acc_wr && acc_out == $past(q.pin_level[P0_LSB +: 4]))
    else $error("port zero read wrong");

  port_one_wr_a: assert property (
    fire && instr_code == OP_WR_PORT_ONE |=> port_one_out == $past(acc_in))
    else $error("port one write wrong");

  port_two_rd_a: assert property (
    fire && instr_code == OP_RD_PORT_TWO
    |=> acc_wr && acc_out[3] == 1'b0 && acc_out[2:0] == $past(q.pin_level[P2_LSB +: 3]))
    else $error("port two read wrong");

  port_two_wr_a: assert property (
    fire && instr_code == OP_WR_PORT_TWO |=> port_two_out == $past(acc_in[2:0]))
    else $error("port two write wrong");

  port_three_rd_a: assert property (
    fire && instr_code == OP_RD_PORT_THREE |=> acc_wr && acc_out[1:0] == $past(q.pin_level[P3_LSB +: 2]))
    else $error("port three read wrong");

  port_three_wr_a: assert property (
    fire && instr_code == OP_WR_PORT_THREE |=> port_three_out == $past(acc_in[1:0]))
    else $error("port three write wrong");

  port_six_rd_a: assert property (
    fire && instr_code == OP_RD_PORT_SIX |=> acc_wr && acc_out == $past(q.pin_level[P6_LSB +: 4]))
    else $error("port six read wrong");

  led_all_a: assert property (
    fire && instr_code == OP_SET_ALL_LED |=> led_port == 8'hff)
    else $error("LED port not all ones");

  led_clear_a: assert property (
    fire && instr_code == OP_CLR_LED_BIT && !index_y[3] |=> led_port[$past(yb)] == 1'b0)
    else $error("LED bit not cleared");

  led_set_a: assert property (
    fire && instr_code == OP_SET_LED_BIT && !index_y[3] |=> led_port[$past(yb)] == 1'b1)
    else $error("LED bit not set");

  led_skip_a: assert property (
    fire && instr_code == OP_SKIP_LED_ZERO && !index_y[3] |=> skip == !$past(q.led[yb]))
    else $error("LED skip wrong");

  pullup_zero_a: assert property (
    fire && instr_code == OP_WR_PULLUP_0 |=> pullup_ctrl_0 == $past(acc_in))
    else $error("pull-up 0 write wrong");

  pullup_zero_rd_a: assert property (
    fire && instr_code == OP_RD_PULLUP_0 |=> acc_wr && acc_out == $past(pullup_ctrl_0))
    else $error("pull-up 0 read wrong");

  pullup_one_rd_a: assert property (
    fire && instr_code == OP_RD_PULLUP_1 |=> acc_wr && acc_out == $past(pullup_ctrl_1))
    else $error("pull-up 1 read wrong");

  pullup_one_a: assert property (
    fire && instr_code == OP_WR_PULLUP_1 |=> pullup_ctrl_1 == $past(acc_in))
    else $error("pull-up 1 write wrong");

  one_cycle_a: assert property (
    fire |=> instr_done)
    else $error("instruction not done in one cycle");

  bus_answer_a: assert property (
    ce && bus_req && waitrequest ##1 ce && $stable(address) && bus_req |-> !waitrequest)
    else $error("bus answer late");

endmodule : pitf_core

// File: verif/pitf_pins.sv
// Board model: every output latch loops back to its own input pins through an inverter.
// Assumes the pins settle well within one clock cycle.
`timescale 1ns/1ps
module pitf_pins (
  input  wire logic [3:0] port_zero_out,
  input  wire logic [3:0] port_one_out,
  input  wire logic [2:0] port_two_out,
  input  wire logic [1:0] port_three_out,
  input  wire logic [3:0] port_six_out,
  output logic      [3:0] port_zero_in,
  output logic      [3:0] port_one_in,
  output logic      [2:0] port_two_in,
  output logic      [1:0] port_three_in,
  output logic      [3:0] port_six_in
);
  assign port_zero_in  = ~port_zero_out;
  assign port_one_in   = ~port_one_out;
  assign port_two_in   = ~port_two_out;
  assign port_three_in = ~port_three_out;
  assign port_six_in   = ~port_six_out;
endmodule : pitf_pins

// File: verif/pitf_tb_top.sv
// Self-checking bench: instructions and Avalon accesses issued by tasks.
// Assumes the inverting loopback board model on the port pins.
`timescale 1ns/1ps
module pitf_tb_top;
  import pitf_pkg::*;
  logic        clk = 0, reset = 1, ce = 1, instr_valid = 0, read = 0, write = 0;
  logic        instr_done, acc_wr, skip, waitrequest, irq;
  logic [9:0]  instr_code = '0;
  logic [3:0]  acc_in = '0, index_y = '0, timer_flag_set = '0, byteenable = 4'hf;
  logic [3:0]  int_control_reg_1 = '0, int_control_reg_2 = '0, timer_flag, acc_out;
  logic [3:0]  port_zero_in, port_one_in, port_six_in, port_zero_out, port_one_out, port_six_out;
  logic [2:0]  port_two_in, port_two_out;
  logic [1:0]  port_three_in, port_three_out;
  logic [7:0]  led_port, exp_led;
  logic [3:0]  pullup_ctrl_0, pullup_ctrl_1, a, m;
  logic [4:0]  address = '0;
  logic [31:0] writedata = '0, readdata, q;
  int          err_count = 0, n_checks = 0;

  pitf_core dut (.clk, .reset, .ce, .instr_valid, .instr_code, .acc_in, .index_y, .int_control_reg_1,
    .int_control_reg_2, .timer_flag_set, .timer_flag, .instr_done, .acc_wr, .acc_out, .skip,
    .port_zero_in, .port_one_in, .port_two_in, .port_three_in, .port_six_in, .port_zero_out,
    .port_one_out, .port_two_out, .port_three_out, .port_six_out, .led_port, .pullup_ctrl_0,
    .pullup_ctrl_1, .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .irq);
  pitf_pins board (.port_zero_out, .port_one_out, .port_two_out, .port_three_out, .port_six_out,
    .port_zero_in, .port_one_in, .port_two_in, .port_three_in, .port_six_in);

  always #25 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic exec(input logic [9:0] code, input logic [3:0] acc, input logic [3:0] y);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_code  <= code;
    acc_in      <= acc;
    index_y     <= y;
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    check(instr_done, 1'b1, "instruction done");
  endtask : exec

  task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    read      <= !wr;
    write     <= wr;
    address   <= adr;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      conclude();
    end
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(negedge clk);
  endtask : bus

  task automatic set_ie(input int n, input logic on);
    logic [7:0] ie;
    int         pos [4];
    pos = '{IE_T1_BIT, IE_T2_BIT, 4 + IE_T3_BIT, 4 + IE_T4_BIT};
    ie = 8'hff;
    ie[pos[n]] = on;
    @(posedge clk);
    int_control_reg_1 <= ie[3:0];
    int_control_reg_2 <= ie[7:4];
  endtask : set_ie

  function automatic logic [3:0] pout(int i);
    case (i)
      0: pout = port_zero_out;
      1: pout = port_one_out;
      2: pout = {1'b0, port_two_out};
      3: pout = {2'b0, port_three_out};
      default: pout = port_six_out;
    endcase
  endfunction : pout

  initial begin
    logic [9:0] wr_op [5];
    logic [9:0] rd_op [5];
    logic [3:0] msk [5];
    wr_op = '{OP_WR_PORT_ZERO, OP_WR_PORT_ONE, OP_WR_PORT_TWO, OP_WR_PORT_THREE, OP_WR_PORT_SIX};
    rd_op = '{OP_RD_PORT_ZERO, OP_RD_PORT_ONE, OP_RD_PORT_TWO, OP_RD_PORT_THREE, OP_RD_PORT_SIX};
    msk = '{4'hf, 4'hf, 4'h7, 4'h3, 4'hf};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check({led_port, pullup_ctrl_0, timer_flag, irq}, 17'h0, "reset state");
    bus(1'b0, 5'h00, 32'h0, q);
    check(q, 32'h0, "status at reset");
    bus(1'b0, 5'h14, 32'h0, q);
    check(q, 32'h0, "unmapped word");
    // Port write then read back through the inverting board
    for (int i = 0; i < 5; i++) begin
      a = 4'h9 + 4'(i);
      m = msk[i];
      exec(wr_op[i], a, 4'h0);
      check(pout(i), a & m, "port latch");
      check(acc_wr, 1'b0, "no acc load on write");
      repeat (5) @(posedge clk);
      exec(rd_op[i], ~a, 4'h0);
      check(acc_wr, 1'b1, "acc load on read");
      check(i == 3 ? acc_out & 4'h3 : acc_out, ~a & m, "port read");
    end
    // Pull-up registers
    exec(OP_WR_PULLUP_0, 4'h5, 4'h0);
    exec(OP_WR_PULLUP_1, 4'ha, 4'h0);
    check({pullup_ctrl_1, pullup_ctrl_0}, 8'ha5, "pull-up latches");
    exec(OP_RD_PULLUP_0, 4'h0, 4'h0);
    check({acc_wr, acc_out}, 5'h15, "pull-up 0 read");
    exec(OP_RD_PULLUP_1, 4'h0, 4'h0);
    check({acc_wr, acc_out}, 5'h1a, "pull-up 1 read");
    // LED port
    exec(OP_SET_ALL_LED, 4'h0, 4'h0);
    check(led_port, 8'hff, "set all");
    exp_led = 8'hff;
    for (int y = 0; y < 8; y++) begin
      exec(OP_CLR_LED_BIT, 4'h0, 4'(y));
      exp_led[y] = 1'b0;
      check(led_port, exp_led, "clear bit");
      exec(OP_SKIP_LED_ZERO, 4'h0, 4'(y));
      check(skip, 1'b1, "skip on zero");
      exec(OP_SKIP_LED_ZERO, 4'h0, 4'((y + 1) % 8));
      check(skip, y == 7, "skip on neighbour");
    end
    for (int y = 7; y >= 0; y--) begin
      exec(OP_SET_LED_BIT, 4'h0, 4'(y));
      exp_led[y] = 1'b1;
      check(led_port, exp_led, "set bit");
    end
    exec(OP_CLR_LED_BIT, 4'h0, 4'h8);
    check(led_port, 8'hff, "index above seven");
    // Timer flag tests, enable set then clear
    for (int n = 0; n < 4; n++) begin
      @(posedge clk);
      timer_flag_set <= 4'h1 << n;
      @(posedge clk);
      timer_flag_set <= 4'h0;
      set_ie(n, 1'b1);
      exec(OP_SKIP_T1 + 10'(n), 4'h0, 4'h0);
      check({skip, timer_flag}, {1'b0, 4'h1 << n}, "enabled test");
      set_ie(n, 1'b0);
      exec(OP_SKIP_T1 + 10'(n), 4'h0, 4'h0);
      check({skip, timer_flag}, 5'h10, "skip and clear");
      exec(OP_SKIP_T1 + 10'(n), 4'h0, 4'h0);
      check(skip, 1'b0, "flag already clear");
    end
    bus(1'b0, 5'h00, 32'h0, q);
    check(q, 32'h1f, "status events");
    check(irq, 1'b0, "masked");
    bus(1'b1, 5'h04, 32'h10, q);
    check(irq, 1'b1, "unmasked");
    bus(1'b1, 5'h00, 32'h1f, q);
    bus(1'b0, 5'h00, 32'h0, q);
    check(q, 32'h0, "cleared");
    check(irq, 1'b0, "irq cleared");
    // Clock enable low freezes the core
    @(posedge clk);
    ce          <= 1'b0;
    instr_valid <= 1'b1;
    instr_code  <= OP_CLR_LED_BIT;
    index_y     <= 4'h0;
    @(posedge clk);
    ce          <= 1'b1;
    instr_valid <= 1'b0;
    @(negedge clk);
    check(instr_done, 1'b0, "no instruction while frozen");
    check(led_port, 8'hff, "LED held while frozen");
    bus(1'b0, 5'h0c, 32'h0, q);
    check(q, 32'h0000a5ff, "state word");
    bus(1'b0, 5'h08, 32'h0, q);
    check(q, 32'h00005c56, "pin word");
    conclude();
  end

  initial begin
    #(50ns * 20000);
    err_count++;
    conclude();
  end
endmodule : pitf_tb_top
